// ### inc/current_calc_map.vh
// Register offsets, field positions and reset values of the current and alert logic
`ifndef CURRENT_CALC_MAP_VH
`define CURRENT_CALC_MAP_VH

// Register offsets
`define ADDR_CURRENT        8'h04
`define ADDR_CALIBRATION    8'h05
`define ADDR_MASK_ENABLE    8'h06

// Reset values
`define RST_CALIBRATION     15'h0000
`define RST_WORD            16'h0000

// Calibration field
`define CAL_MSB             14
`define CAL_LSB             0

// Mask and enable fields
`define BIT_SHUNT_OVER      15
`define BIT_SHUNT_UNDER     14
`define BIT_BUS_OVER        13
`define BIT_BUS_UNDER       12
`define BIT_POWER_OVER      11
`define BIT_CONV_ALERT      10
`define BIT_LIMIT_FLAG      4
`define BIT_CONV_FLAG       3
`define BIT_OVF_FLAG        2
`define BIT_POLARITY        1
`define BIT_LATCH           0

// Selected limit function codes
`define SEL_NONE            3'h0
`define SEL_SHUNT_OVER      3'h1
`define SEL_SHUNT_UNDER     3'h2
`define SEL_BUS_OVER        3'h3
`define SEL_BUS_UNDER       3'h4
`define SEL_POWER_OVER      3'h5

// Current scaling: product is shifted right by this amount
`define CUR_SHIFT           11
`define CUR_MAX             16'h7fff
`define CUR_MIN             16'h8000

`endif

// ### verilog/current_mult.v
// Signed shunt reading times calibration value, saturated to the current register
`timescale 1ns/1ps
`include "current_calc_map.vh"

module current_mult
(
    input  wire        clk_i,
    input  wire        srst_i,
    input  wire        start_i,
    input  wire [15:0] shunt_i,
    input  wire [14:0] cal_i,
    output reg  [15:0] current_q,
    output reg         ovf_q,
    output reg         done_q
);

    wire signed [31:0] product;
    wire signed [31:0] scaled;
    wire               too_big;
    wire               too_small;

    // ------------------------------------------------------------------
    // Multiply and scale
    // ------------------------------------------------------------------
    assign product   = $signed(shunt_i) * $signed({1'b0, cal_i});
    assign scaled    = product >>> `CUR_SHIFT;
    assign too_big   = scaled > $signed({16'h0000, `CUR_MAX});
    assign too_small = scaled < $signed({16'hffff, `CUR_MIN});

    // ------------------------------------------------------------------
    // Result register
    // ------------------------------------------------------------------
    always @(posedge clk_i)
    begin
        if (srst_i)
        begin
            current_q <= `RST_WORD;
            ovf_q     <= 1'b0;
            done_q    <= 1'b0;
        end
        else
        begin
            done_q <= start_i;
            if (start_i)
            begin
                ovf_q <= too_big | too_small;
                if (too_big)
                    current_q <= `CUR_MAX;
                else if (too_small)
                    current_q <= `CUR_MIN;
                else
                    current_q <= scaled[15:0];
            end
        end
    end

endmodule // current_mult

// ### verilog/current_alert.v
// Current result, calibration and alert mask/enable register logic
`timescale 1ns/1ps
`include "current_calc_map.vh"

module current_alert
(
    input  wire        CLK_I,
    input  wire        SRST_I,
    input  wire [7:0]  REG_ADDR_I,
    input  wire        REG_WR_I,
    input  wire        REG_RD_I,
    input  wire [15:0] REG_WDATA_I,
    output reg  [15:0] REG_RDATA_O,
    input  wire [15:0] SHUNT_I,
    input  wire        SHUNT_VALID_I,
    input  wire [15:0] BUS_I,
    input  wire        BUS_VALID_I,
    input  wire [15:0] POWER_I,
    input  wire        POWER_VALID_I,
    input  wire [15:0] ALERT_LIMIT_I,
    input  wire        CONV_DONE_I,
    input  wire        SINGLE_SHOT_I,
    input  wire        CFG_WR_I,
    output wire [15:0] CURRENT_O,
    output wire        ALERT_O,
    output wire        ALERT_OE_O
);

    reg  [14:0] cal_q;
    reg  [5:0]  enable_q;
    reg         pol_q;
    reg         latch_q;
    reg         limit_flag_q;
    reg         conv_flag_q;
    reg         alert_q;
    reg  [2:0]  sel;
    reg         eval;
    reg         hit;
    wire        mask_read;
    wire        mult_ovf;
    wire        shunt_over_limit_enable;
    wire        shunt_under_limit_enable;
    wire        bus_over_limit_enable;
    wire        bus_under_limit_enable;
    wire        power_over_limit_enable;
    wire        conv_ready_alert_enable;
    wire        alert_active;
    wire [15:0] mask_word;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function is_addr;
        input [7:0] addr;
        input [7:0] target;
        begin
            is_addr = (addr == target);
        end
    endfunction

    function signed_gt;
        input [15:0] a;
        input [15:0] b;
        begin
            signed_gt = $signed(a) > $signed(b);
        end
    endfunction

    // ------------------------------------------------------------------
    // Current calculation
    // ------------------------------------------------------------------
    current_mult u_mult
    (
        .clk_i     (CLK_I),
        .srst_i    (SRST_I),
        .start_i   (SHUNT_VALID_I),
        .shunt_i   (SHUNT_I),
        .cal_i     (cal_q),
        .current_q (CURRENT_O),
        .ovf_q     (mult_ovf),
        .done_q    ()
    );

    // ------------------------------------------------------------------
    // Field aliases
    // ------------------------------------------------------------------
    assign shunt_over_limit_enable  = enable_q[5];
    assign shunt_under_limit_enable = enable_q[4];
    assign bus_over_limit_enable    = enable_q[3];
    assign bus_under_limit_enable   = enable_q[2];
    assign power_over_limit_enable  = enable_q[1];
    assign conv_ready_alert_enable  = enable_q[0];

    assign mask_read = REG_RD_I & is_addr(REG_ADDR_I, `ADDR_MASK_ENABLE);

    assign mask_word = {enable_q, 5'h00, limit_flag_q, conv_flag_q, mult_ovf, pol_q, latch_q};

    // ------------------------------------------------------------------
    // Limit function select and compare
    // ------------------------------------------------------------------
    always @*
    begin
        if (shunt_over_limit_enable)
            sel = `SEL_SHUNT_OVER;
        else if (shunt_under_limit_enable)
            sel = `SEL_SHUNT_UNDER;
        else if (bus_over_limit_enable)
            sel = `SEL_BUS_OVER;
        else if (bus_under_limit_enable)
            sel = `SEL_BUS_UNDER;
        else if (power_over_limit_enable)
            sel = `SEL_POWER_OVER;
        else
            sel = `SEL_NONE;
    end

    always @*
    begin
        eval = 1'b0;
        hit  = 1'b0;
        case (sel)
            `SEL_SHUNT_OVER:
            begin
                eval = SHUNT_VALID_I;
                hit  = signed_gt(SHUNT_I, ALERT_LIMIT_I);
            end
            `SEL_SHUNT_UNDER:
            begin
                eval = SHUNT_VALID_I;
                hit  = signed_gt(ALERT_LIMIT_I, SHUNT_I);
            end
            `SEL_BUS_OVER:
            begin
                eval = BUS_VALID_I;
                hit  = BUS_I > ALERT_LIMIT_I;
            end
            `SEL_BUS_UNDER:
            begin
                eval = BUS_VALID_I;
                hit  = BUS_I < ALERT_LIMIT_I;
            end
            `SEL_POWER_OVER:
            begin
                eval = POWER_VALID_I;
                hit  = POWER_I > ALERT_LIMIT_I;
            end
            default:
            begin
                eval = 1'b0;
                hit  = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Registers and flags
    // ------------------------------------------------------------------
    always @(posedge CLK_I)
    begin
        if (SRST_I)
        begin
            cal_q        <= `RST_CALIBRATION;
            enable_q     <= 6'h00;
            pol_q        <= 1'b0;
            latch_q      <= 1'b0;
            limit_flag_q <= 1'b0;
            conv_flag_q  <= 1'b0;
        end
        else
        begin
            if (REG_WR_I && is_addr(REG_ADDR_I, `ADDR_CALIBRATION))
                cal_q <= REG_WDATA_I[`CAL_MSB:`CAL_LSB];
            if (REG_WR_I && is_addr(REG_ADDR_I, `ADDR_MASK_ENABLE))
            begin
                enable_q <= REG_WDATA_I[`BIT_SHUNT_OVER:`BIT_CONV_ALERT];
                pol_q    <= REG_WDATA_I[`BIT_POLARITY];
                latch_q  <= REG_WDATA_I[`BIT_LATCH];
            end
            // Limit flag: set wins over any clear
            if (eval && hit)
                limit_flag_q <= 1'b1;
            else if (latch_q ? mask_read : (eval && !hit))
                limit_flag_q <= 1'b0;
            // Conversion flag: set wins over any clear
            if (CONV_DONE_I)
                conv_flag_q <= 1'b1;
            else if (SINGLE_SHOT_I && (CFG_WR_I || mask_read))
                conv_flag_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    always @(posedge CLK_I)
    begin
        if (SRST_I)
            REG_RDATA_O <= `RST_WORD;
        else if (REG_RD_I)
        begin
            if (is_addr(REG_ADDR_I, `ADDR_CURRENT))
                REG_RDATA_O <= CURRENT_O;
            else if (is_addr(REG_ADDR_I, `ADDR_CALIBRATION))
                REG_RDATA_O <= {1'b0, cal_q};
            else if (is_addr(REG_ADDR_I, `ADDR_MASK_ENABLE))
                REG_RDATA_O <= mask_word;
            else
                REG_RDATA_O <= `RST_WORD;
        end
    end

    // ------------------------------------------------------------------
    // Alert pin
    // ------------------------------------------------------------------
    assign alert_active = limit_flag_q | (conv_ready_alert_enable & conv_flag_q);

    always @(posedge CLK_I)
    begin
        if (SRST_I)
            alert_q <= 1'b0;
        else
            alert_q <= alert_active;
    end

    // Open collector: pulls low while the pin sits at its low level
    assign ALERT_O    = 1'b0;
    assign ALERT_OE_O = alert_q ^ pol_q;

endmodule // current_alert

// ### tb/current_alert_assertions.sv
// Concurrent checks on the current and alert register block
`timescale 1ns/1ps
module current_alert_assertions
(
    input wire logic        CLK_I,
    input wire logic        SRST_I,
    input wire logic [7:0]  REG_ADDR_I,
    input wire logic        REG_WR_I,
    input wire logic        REG_RD_I,
    input wire logic [15:0] REG_WDATA_I,
    input wire logic [15:0] REG_RDATA_O,
    input wire logic [15:0] SHUNT_I,
    input wire logic        SHUNT_VALID_I,
    input wire logic [15:0] ALERT_LIMIT_I,
    input wire logic        CONV_DONE_I,
    input wire logic [15:0] CURRENT_O,
    input wire logic        ALERT_O,
    input wire logic        ALERT_OE_O
);
    reg [15:0] msk_q;
    // ------
    // Mask copy
    // ------
    always @(posedge CLK_I)
        if (SRST_I)
            msk_q <= 16'h0000;
        else if (REG_WR_I && REG_ADDR_I == 8'h06)
            msk_q <= REG_WDATA_I;
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (SRST_I);
    chk_pin_data_low: assert property (ALERT_O == 1'b0) else $error("alert data not low");
    chk_reset_pin_idle: assert property ($fell(SRST_I) |-> !ALERT_OE_O) else $error("pin not idle");
    chk_mask_read_back: assert property (REG_RD_I && REG_ADDR_I == 8'h06 |=> REG_RDATA_O[15:5] ==
        {$past(msk_q[15:10]), 5'h00} && REG_RDATA_O[1:0] == $past(msk_q[1:0])) else $error("mask readback");
    chk_cal_read_back: assert property (REG_WR_I && REG_ADDR_I == 8'h05 ##2 REG_RD_I && REG_ADDR_I == 8'h05
        |=> REG_RDATA_O == {1'b0, $past(REG_WDATA_I[14:0], 3)}) else $error("cal readback");
    chk_unmapped_zero: assert property (REG_RD_I && (REG_ADDR_I < 8'h04 || REG_ADDR_I > 8'h06)
        |=> REG_RDATA_O == 16'h0000) else $error("unmapped read");
    chk_cur_read: assert property (REG_RD_I && REG_ADDR_I == 8'h04 |=> REG_RDATA_O == $past(CURRENT_O))
        else $error("current read");
    chk_cur_holds: assert property (!SHUNT_VALID_I |=> $stable(CURRENT_O)) else $error("current moved");
    chk_shunt_over_pin: assert property (msk_q[15] && !msk_q[1] && SHUNT_VALID_I &&
        $signed(SHUNT_I) > $signed(ALERT_LIMIT_I) |=> ##1 ALERT_OE_O) else $error("shunt over alert");
    chk_conv_pin: assert property (msk_q[10] && !msk_q[1] && CONV_DONE_I |=> ##1 ALERT_OE_O)
        else $error("conv alert");
endmodule // current_alert_assertions

// ### tb/reg_host.sv
// Register host model for the block's register port
`timescale 1ns/1ps
module reg_host
(
    input  wire        clk_i,
    output reg  [7:0]  addr_o,
    output reg         wr_o,
    output reg         rd_o,
    output reg  [15:0] wdata_o,
    input  wire [15:0] rdata_i
);
    initial
    begin
        addr_o = 8'h00;
        wr_o = 1'b0;
        rd_o = 1'b0;
        wdata_o = 16'h0000;
    end
    task wr(input [7:0] a, input [15:0] d);
    begin
        addr_o = a;
        wdata_o = d;
        wr_o = 1'b1;
        @(posedge clk_i);
        #1;
        wr_o = 1'b0;
        addr_o = ~a;
        wdata_o = ~d;
        // Idle edge between calls
        @(posedge clk_i);
        #1;
    end
    endtask
    task rd(input [7:0] a, output [15:0] d);
    begin
        addr_o = a;
        rd_o = 1'b1;
        @(posedge clk_i);
        #1;
        rd_o = 1'b0;
        addr_o = ~a;
        d = rdata_i;
        @(posedge clk_i);
        #1;
    end
    endtask
endmodule // reg_host

// ### tb/current_alert_tb.sv
// Self-checking bench for the current and alert register block
`timescale 1ns/1ps
module current_alert_tb;
    reg clk, srst, sv, bv, pv, cdone, ss, cfg;
    reg [15:0] shunt, bus, pwr, lim, d;
    wire [7:0] addr;
    wire wr, rd, alert, oe;
    wire [15:0] wdata, rdata, cur;
    integer error_cnt, n_tests, i;
    reg_host i_reg_host (.clk_i(clk), .addr_o(addr), .wr_o(wr), .rd_o(rd), .wdata_o(wdata), .rdata_i(rdata));
    current_alert i_current_alert (.CLK_I(clk), .SRST_I(srst), .REG_ADDR_I(addr), .REG_WR_I(wr), .REG_RD_I(rd),
        .REG_WDATA_I(wdata), .REG_RDATA_O(rdata), .SHUNT_I(shunt), .SHUNT_VALID_I(sv), .BUS_I(bus),
        .BUS_VALID_I(bv), .POWER_I(pwr), .POWER_VALID_I(pv), .ALERT_LIMIT_I(lim), .CONV_DONE_I(cdone),
        .SINGLE_SHOT_I(ss), .CFG_WR_I(cfg), .CURRENT_O(cur), .ALERT_O(alert), .ALERT_OE_O(oe));
    // ------
    // Helpers
    // ------
    task cyc(input integer n);
    begin
        repeat (n) @(posedge clk);
        #1;
    end
    endtask
    task chk(input [15:0] got, input [15:0] exp);
    begin
        n_tests = n_tests + 1;
        if (got !== exp)
        begin
            error_cnt = error_cnt + 1;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    end
    endtask
    task pulse(input [1:0] src, input [15:0] v);
    begin
        shunt = v;
        bus = v;
        pwr = v;
        sv = (src == 2'd0);
        bv = (src == 2'd1);
        pv = (src == 2'd2);
        cyc(1);
        sv = 1'b0;
        bv = 1'b0;
        pv = 1'b0;
        cyc(2);
    end
    endtask
    task print_verdict;
    begin
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    end
    endtask
    // ------
    // Scenarios
    // ------
    task t_regs;
    begin
        i_reg_host.rd(8'h05, d);
        chk(d, 16'h0000);
        i_reg_host.rd(8'h06, d);
        chk(d, 16'h0000);
        i_reg_host.wr(8'h05, 16'hffff);
        i_reg_host.rd(8'h05, d);
        chk(d, 16'h7fff);
        i_reg_host.rd(8'h07, d);
        chk(d, 16'h0000);
        $display("regs done");
    end
    endtask
    task t_current;
    begin
        pulse(2'd0, 16'h7fff);
        chk(cur, 16'h7fff);
        i_reg_host.rd(8'h06, d);
        chk(d & 16'h0004, 16'h0004);
        pulse(2'd0, 16'h8000);
        chk(cur, 16'h8000);
        i_reg_host.wr(8'h05, 16'h0800);
        pulse(2'd0, 16'hff00);
        i_reg_host.rd(8'h04, d);
        chk(d, 16'hff00);
        i_reg_host.rd(8'h06, d);
        chk(d & 16'h0004, 16'h0000);
        $display("current done");
    end
    endtask
    task t_limits;
    begin
        for (i = 0; i < 5; i = i + 1)
        begin
            i_reg_host.wr(8'h06, 16'h8000 >> i);
            pulse(i[2:1], i == 1 ? 16'hff00 : i == 3 ? 16'h0050 : 16'h0200);
            chk({15'h0000, oe}, 16'h0001);
            i_reg_host.rd(8'h06, d);
            chk(d & 16'h0010, 16'h0010);
            pulse(i[2:1], i[0] ? 16'h0200 : 16'h0050);
            chk({15'h0000, oe}, 16'h0000);
        end
        i_reg_host.wr(8'h06, 16'hc000);
        pulse(2'd0, 16'hff00);
        chk({15'h0000, oe}, 16'h0000);
        $display("limits done");
    end
    endtask
    task t_latch;
    begin
        i_reg_host.wr(8'h06, 16'h8001);
        pulse(2'd0, 16'h0200);
        pulse(2'd0, 16'h0050);
        chk({15'h0000, oe}, 16'h0001);
        i_reg_host.rd(8'h06, d);
        chk(d & 16'h0010, 16'h0010);
        cyc(2);
        chk({15'h0000, oe}, 16'h0000);
        i_reg_host.wr(8'h06, 16'h8002);
        cyc(2);
        chk({15'h0000, oe}, 16'h0001);
        pulse(2'd0, 16'h0200);
        chk({15'h0000, oe}, 16'h0000);
        pulse(2'd0, 16'h0050);
        chk({15'h0000, oe}, 16'h0001);
        $display("latch done");
    end
    endtask
    task t_conv;
    begin
        ss = 1'b1;
        i_reg_host.wr(8'h06, 16'h8400);
        cdone = 1'b1;
        cyc(1);
        cdone = 1'b0;
        cyc(1);
        chk({15'h0000, oe}, 16'h0001);
        i_reg_host.rd(8'h06, d);
        chk(d & 16'h0008, 16'h0008);
        i_reg_host.rd(8'h06, d);
        chk(d & 16'h0008, 16'h0000);
        chk({15'h0000, oe}, 16'h0000);
        cdone = 1'b1;
        cyc(1);
        cdone = 1'b0;
        cfg = 1'b1;
        cyc(1);
        cfg = 1'b0;
        i_reg_host.rd(8'h06, d);
        chk(d & 16'h0008, 16'h0000);
        ss = 1'b0;
        cdone = 1'b1;
        cyc(1);
        cdone = 1'b0;
        i_reg_host.rd(8'h06, d);
        i_reg_host.rd(8'h06, d);
        chk(d & 16'h0008, 16'h0008);
        $display("conv done");
    end
    endtask
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial
    begin
        {srst, sv, bv, pv, cdone, ss, cfg} = 7'h40;
        {shunt, bus, pwr} = 48'h0;
        lim = 16'h0100;
        error_cnt = 0;
        n_tests = 0;
        cyc(16);
        srst = 1'b0;
        t_regs;
        t_current;
        t_limits;
        t_latch;
        t_conv;
        print_verdict;
    end
    initial
    begin
        #20000;
        error_cnt = error_cnt + 1;
        print_verdict;
    end
endmodule // current_alert_tb
bind current_alert current_alert_assertions i_current_alert_assertions (.CLK_I(CLK_I), .SRST_I(SRST_I),
    .REG_ADDR_I(REG_ADDR_I), .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I), .REG_WDATA_I(REG_WDATA_I),
    .REG_RDATA_O(REG_RDATA_O), .SHUNT_I(SHUNT_I), .SHUNT_VALID_I(SHUNT_VALID_I), .ALERT_LIMIT_I(ALERT_LIMIT_I),
    .CONV_DONE_I(CONV_DONE_I), .CURRENT_O(CURRENT_O), .ALERT_O(ALERT_O), .ALERT_OE_O(ALERT_OE_O));
